// ===== mswc_pkg.sv
// shared constants, carrier structs and enums of the multi-stream write combiner
// assumes every user compiles this package first and names items as mswc_pkg::name
// Notes on behaviour
// [R1] up to four line buffers, count is a parameter
// [R2] streaming stores share the same buffer pool
// [R3] one buffer holds one aligned 64-byte stream
// [R4] flush emits open buffers in opening order
// [R5] line 40h opened first leaves before 00h
// [R6] uncacheable read empties all open buffers
// [R7] write to extra line may evict oldest buffer
// [R8] bridge chains ascending sequential packets into bursts
// [R9] bridge splits non-sequential packets into transactions
// [R10] bridge: one address phase per chained burst
// [R11] bridge: one command phase per fast-write burst
// [R12] software fills lines in ascending address order
// [R13] a fully valid buffer closes and leaves
// [R14] writes merge in any order within line
// [R15] per-byte valid mask and open-order tag kept
// [R16] hit merges without reopening or reordering buffer
package mswc_pkg;

  localparam int unsigned LINE_BYTES = 64;
  localparam int unsigned QW_BYTES = 8;
  localparam int unsigned QW_PER_LINE = LINE_BYTES / QW_BYTES;
  localparam int unsigned QW_IDX_W = $clog2(QW_PER_LINE);
  localparam int unsigned LINE_ADDR_W = 26;
  localparam int unsigned NUM_BUFS = 4;
  localparam int unsigned FIFO_DEPTH = 4;

  localparam logic [LINE_BYTES-1:0] MASK_RST = {LINE_BYTES{1'b0}};
  localparam logic [LINE_BYTES-1:0] MASK_FULL = {LINE_BYTES{1'b1}};
  localparam logic [LINE_BYTES*8-1:0] DATA_RST = {(LINE_BYTES*8){1'b0}};
  localparam logic [LINE_ADDR_W-1:0] LINE_RST = {LINE_ADDR_W{1'b0}};
  localparam logic WR_READY_RST = 1'b1;

  typedef enum logic [1:0] {
    write_combining_type,
    streaming_store_type,
    uncacheable_type
  } mswc_mtype_e;

  // one quadword write from the core
  typedef struct packed {
    logic [LINE_ADDR_W-1:0] line_addr;
    logic [QW_IDX_W-1:0] qw_idx;
    logic [QW_BYTES*8-1:0] data;
    logic [QW_BYTES-1:0] be;
    mswc_mtype_e mtype;
  } mswc_wr_s;

  // one line packet toward the link
  typedef struct packed {
    logic [LINE_ADDR_W-1:0] line_addr;
    logic [LINE_BYTES*8-1:0] data;
    logic [LINE_BYTES-1:0] mask;
  } mswc_pkt_s;

  localparam int unsigned PKT_W = $bits(mswc_pkt_s);
  localparam logic [PKT_W-1:0] PKT_RST = {PKT_W{1'b0}};

endpackage

// ===== mswc_fifo.sv
// shift-register fifo for outgoing line packets, head always in slot 0
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/100ps
module mswc_fifo #(
  parameter int unsigned WIDTH = mswc_pkg::PKT_W,
  parameter int unsigned DEPTH = mswc_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] vld_nxt;
  logic pop;
  logic push;

  assign pop = vld_r[0] & out_ready_in;
  // a pop in the same cycle frees the top slot
  assign in_ready_out = ~vld_r[DEPTH-1] | pop;
  assign push = in_valid_in & in_ready_out;
  assign out_valid_out = vld_r[0];
  assign out_data_out = mem_r[0];

  always_comb begin
    logic placed;
    placed = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (pop && (i + 1 < DEPTH)) begin
        mem_nxt[i] = mem_r[i+1];
        vld_nxt[i] = vld_r[i+1];
      end else begin
        mem_nxt[i] = mem_r[i];
        vld_nxt[i] = vld_r[i] & ~pop;
      end
    end
    for (int i = 0; i < DEPTH; i++) begin
      if (push && !placed && !vld_nxt[i]) begin
        mem_nxt[i] = in_data_in;
        vld_nxt[i] = 1'b1;
        placed = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      vld_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      vld_r <= vld_nxt;
      mem_r <= mem_nxt;
    end
  end

endmodule

// ===== mswc_top.sv
// multi-stream write combiner: line buffers, open-order flush, packet fifo
// assumes write requests and flush events come from core logic on clk_sys_in
`timescale 1ns/100ps
module mswc_top #(
  parameter int unsigned NUM_BUFS_P = mswc_pkg::NUM_BUFS,
  parameter int unsigned FIFO_DEPTH_P = mswc_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic wr_valid_in,
  input wire mswc_pkg::mswc_wr_s wr_req_in,
  output logic wr_ready_out,
  input wire logic flush_in,
  input wire logic uc_read_in,
  output logic pkt_valid_out,
  input wire logic pkt_ready_in,
  output mswc_pkg::mswc_pkt_s pkt_out,
  output logic [$clog2(NUM_BUFS_P+1)-1:0] open_count_out,
  output logic draining_out
);

  localparam int unsigned NB = NUM_BUFS_P; // [R1]
  localparam int unsigned SEQ_W = (NB > 1) ? $clog2(NB) : 1;
  localparam int unsigned CNT_W = $clog2(NB + 1);
  localparam int unsigned LB = mswc_pkg::LINE_BYTES;
  localparam int unsigned QB = mswc_pkg::QW_BYTES;

  typedef logic [SEQ_W-1:0] mswc_seq_t;

  // place one quadword into a line image
  function automatic logic [LB*8-1:0] merge_data(
    input logic [LB*8-1:0] d,
    input logic [mswc_pkg::QW_IDX_W-1:0] q,
    input logic [QB*8-1:0] w,
    input logic [QB-1:0] be
  );
    logic [LB*8-1:0] r;
    r = d;
    for (int b = 0; b < QB; b++) begin
      if (be[b]) begin
        r[(int'(q) * QB + b) * 8 +: 8] = w[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // set byte valid bits for one quadword
  function automatic logic [LB-1:0] merge_mask(
    input logic [LB-1:0] m,
    input logic [mswc_pkg::QW_IDX_W-1:0] q,
    input logic [QB-1:0] be
  );
    logic [LB-1:0] r;
    r = m;
    r[int'(q) * QB +: QB] = m[int'(q) * QB +: QB] | be;
    return r;
  endfunction

  // lowest set index
  function automatic mswc_seq_t first_set(input logic [NB-1:0] v);
    mswc_seq_t idx;
    idx = '0;
    for (int i = NB - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = SEQ_W'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [CNT_W-1:0] count_set(input logic [NB-1:0] v);
    logic [CNT_W-1:0] c;
    c = '0;
    for (int i = 0; i < NB; i++) begin
      c = c + CNT_W'(v[i]);
    end
    return c;
  endfunction

  // buffer state: one aligned line per buffer, mask and open-order tag
  logic [NB-1:0] vld_r; // [R3]
  logic [NB-1:0] vld_nxt;
  logic [NB-1:0] closed_r;
  logic [NB-1:0] closed_nxt;
  logic [mswc_pkg::LINE_ADDR_W-1:0] line_r [NB];
  logic [mswc_pkg::LINE_ADDR_W-1:0] line_nxt [NB];
  logic [LB*8-1:0] data_r [NB];
  logic [LB*8-1:0] data_nxt [NB];
  logic [LB-1:0] mask_r [NB]; // [R15]
  logic [LB-1:0] mask_nxt [NB];
  mswc_seq_t seq_r [NB]; // [R15]
  mswc_seq_t seq_nxt [NB];

  logic hold_v_r;
  logic hold_v_nxt;
  mswc_pkg::mswc_wr_s hold_r;
  mswc_pkg::mswc_wr_s hold_nxt;
  logic wr_ready_r;
  logic drain_r;
  logic drain_nxt;
  logic [CNT_W-1:0] open_cnt_r;

  logic [NB-1:0] hit_vec;
  logic [NB-1:0] free_vec;
  logic [NB-1:0] old_vec;
  logic [NB-1:0] closed_vec;

  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_vec
      assign hit_vec[g] = vld_r[g] & (line_r[g] == hold_r.line_addr);
      assign free_vec[g] = ~vld_r[g];
      assign old_vec[g] = vld_r[g] & (seq_r[g] == '0);
      assign closed_vec[g] = vld_r[g] & closed_r[g];
    end
  endgenerate

  logic hit_any;
  logic free_any;
  logic open_any;
  logic closed_any;
  mswc_seq_t hit_idx;
  mswc_seq_t free_idx;
  mswc_seq_t oldest_idx;
  mswc_seq_t closed_idx;
  logic [CNT_W-1:0] open_cnt;

  assign hit_any = |hit_vec;
  assign free_any = |free_vec;
  assign open_any = |vld_r;
  assign closed_any = |closed_vec;
  assign hit_idx = first_set(hit_vec);
  assign free_idx = first_set(free_vec);
  assign oldest_idx = first_set(old_vec);
  assign closed_idx = first_set(closed_vec);
  assign open_cnt = count_set(vld_r);

  logic emit_req;
  mswc_seq_t emit_idx;
  // full buffers leave first, then the drain walks open order
  assign emit_req = closed_any | (drain_r & open_any); // [R13] [R4]
  assign emit_idx = closed_any ? closed_idx : oldest_idx; // [R4] [R5]

  wire fifo_in_ready;
  logic proc_ok;
  logic is_uc;
  logic uc_trig;
  logic uc_go;
  logic merge_go;
  logic open_free;
  logic evict_go;
  logic open_go;
  logic emit_go;
  logic rm_go;
  mswc_seq_t rm_idx;
  mswc_seq_t open_idx;
  mswc_seq_t open_seq;
  logic hold_done;
  logic wr_take;

  assign proc_ok = hold_v_r & ~emit_req & ~drain_r;
  // streaming stores take the same path as write-combining writes
  assign is_uc = (hold_r.mtype == mswc_pkg::uncacheable_type); // [R2]
  assign uc_trig = proc_ok & is_uc & open_any;
  assign uc_go = proc_ok & is_uc & ~open_any & fifo_in_ready;
  assign merge_go = proc_ok & ~is_uc & hit_any; // [R16]
  assign open_free = proc_ok & ~is_uc & ~hit_any & free_any;
  // no free buffer: the oldest stream is sent out and its slot reused
  assign evict_go = proc_ok & ~is_uc & ~hit_any & ~free_any & fifo_in_ready; // [R7]
  assign open_go = open_free | evict_go;
  assign emit_go = emit_req & fifo_in_ready;
  assign rm_go = emit_go | evict_go;
  assign rm_idx = emit_go ? emit_idx : oldest_idx;
  assign open_idx = free_any ? free_idx : oldest_idx;
  // a new stream goes to the back of the open order
  assign open_seq = free_any ? open_cnt[SEQ_W-1:0] : SEQ_W'(NB - 1); // [R4]
  assign hold_done = uc_go | merge_go | open_go;
  assign wr_take = wr_valid_in & wr_ready_r;

  wire [LB*8-1:0] hold_line_data = merge_data(mswc_pkg::DATA_RST, hold_r.qw_idx,
                                              hold_r.data, hold_r.be);
  wire [LB-1:0] hold_line_mask = merge_mask(mswc_pkg::MASK_RST, hold_r.qw_idx, hold_r.be);

  mswc_pkg::mswc_pkt_s push_pkt;
  always_comb begin
    if (uc_go) begin
      push_pkt.line_addr = hold_r.line_addr;
      push_pkt.data = hold_line_data;
      push_pkt.mask = hold_line_mask;
    end else begin
      push_pkt.line_addr = line_r[rm_idx];
      push_pkt.data = data_r[rm_idx];
      push_pkt.mask = mask_r[rm_idx];
    end
  end

  always_comb begin
    logic [LB-1:0] m;
    m = '0;
    for (int i = 0; i < NB; i++) begin
      vld_nxt[i] = vld_r[i];
      closed_nxt[i] = closed_r[i];
      line_nxt[i] = line_r[i];
      data_nxt[i] = data_r[i];
      mask_nxt[i] = mask_r[i];
      seq_nxt[i] = seq_r[i];
    end
    if (rm_go) begin
      vld_nxt[rm_idx] = 1'b0;
      closed_nxt[rm_idx] = 1'b0;
      mask_nxt[rm_idx] = mswc_pkg::MASK_RST;
      for (int j = 0; j < NB; j++) begin
        if (vld_r[j] && (seq_r[j] > seq_r[rm_idx])) begin
          seq_nxt[j] = seq_r[j] - 1'b1; // [R4]
        end
      end
    end
    if (merge_go) begin
      // any byte order inside the line; open-order tag untouched
      m = merge_mask(mask_r[hit_idx], hold_r.qw_idx, hold_r.be); // [R14] [R16]
      data_nxt[hit_idx] = merge_data(data_r[hit_idx], hold_r.qw_idx, hold_r.data, hold_r.be);
      mask_nxt[hit_idx] = m;
      closed_nxt[hit_idx] = (m == mswc_pkg::MASK_FULL); // [R13]
    end
    if (open_go) begin
      vld_nxt[open_idx] = 1'b1;
      line_nxt[open_idx] = hold_r.line_addr; // [R3]
      data_nxt[open_idx] = hold_line_data;
      mask_nxt[open_idx] = hold_line_mask;
      seq_nxt[open_idx] = open_seq; // [R15]
      closed_nxt[open_idx] = (hold_line_mask == mswc_pkg::MASK_FULL); // [R13]
    end
  end

  // flush, uncacheable read or an uncacheable write with a buffer open starts a full drain
  wire drain_set = flush_in | uc_read_in | uc_trig; // [R6] [R4]
  assign drain_nxt = drain_set | (drain_r & (|vld_nxt));

  always_comb begin
    hold_nxt = hold_r;
    hold_v_nxt = hold_v_r & ~hold_done;
    if (wr_take) begin
      hold_nxt = wr_req_in;
      hold_v_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      vld_r <= '0;
      closed_r <= '0;
      for (int i = 0; i < NB; i++) begin
        line_r[i] <= mswc_pkg::LINE_RST;
        data_r[i] <= mswc_pkg::DATA_RST;
        mask_r[i] <= mswc_pkg::MASK_RST;
        seq_r[i] <= '0;
      end
    end else begin
      vld_r <= vld_nxt;
      closed_r <= closed_nxt;
      line_r <= line_nxt;
      data_r <= data_nxt;
      mask_r <= mask_nxt;
      seq_r <= seq_nxt;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_v_r <= 1'b0;
      hold_r <= '0;
      wr_ready_r <= mswc_pkg::WR_READY_RST;
      drain_r <= 1'b0;
      open_cnt_r <= '0;
    end else begin
      hold_v_r <= hold_v_nxt;
      hold_r <= hold_nxt;
      wr_ready_r <= ~hold_v_nxt;
      drain_r <= drain_nxt;
      open_cnt_r <= count_set(vld_nxt);
    end
  end

  assign wr_ready_out = wr_ready_r;
  assign draining_out = drain_r;
  assign open_count_out = open_cnt_r;

  logic [mswc_pkg::PKT_W-1:0] fifo_out_data;

  mswc_fifo #(
    .WIDTH(mswc_pkg::PKT_W),
    .DEPTH(FIFO_DEPTH_P)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(rm_go | uc_go),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_pkt),
    .out_valid_out(pkt_valid_out),
    .out_ready_in(pkt_ready_in),
    .out_data_out(fifo_out_data)
  );

  assign pkt_out = mswc_pkg::mswc_pkt_s'(fifo_out_data);

endmodule

// ===== mswc_top_sva.sv
// port checker of the write combiner top
// assumes it is bound onto mswc_top
`timescale 1ns/100ps
module mswc_top_sva #(
  parameter int unsigned NUM_BUFS_P = 4
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic wr_valid_in,
  input wire mswc_pkg::mswc_wr_s wr_req_in,
  input wire logic wr_ready_out,
  input wire logic flush_in,
  input wire logic uc_read_in,
  input wire logic pkt_valid_out,
  input wire logic pkt_ready_in,
  input wire mswc_pkg::mswc_pkt_s pkt_out,
  input wire logic [$clog2(NUM_BUFS_P+1)-1:0] open_count_out,
  input wire logic draining_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  property p_cnt_max; open_count_out <= NUM_BUFS_P; endproperty
  a_cnt_max: assert property (p_cnt_max)
    else $error("open buffer count above pool size");
  property p_flush; flush_in |=> draining_out; endproperty
  a_flush: assert property (p_flush)
    else $error("flush did not start a drain");
  property p_ucrd; uc_read_in |=> draining_out; endproperty
  a_ucrd: assert property (p_ucrd)
    else $error("uncacheable read did not start a drain");
  property p_empty; $fell(draining_out) |-> open_count_out == 0; endproperty
  a_empty: assert property (p_empty)
    else $error("drain ended with buffers open");
  property p_grow;
    open_count_out > $past(open_count_out) |-> open_count_out == $past(open_count_out) + 1;
  endproperty
  a_grow: assert property (p_grow)
    else $error("more than one buffer opened at once");
  property p_hold; pkt_valid_out && !pkt_ready_in |=> pkt_valid_out && $stable(pkt_out); endproperty
  a_hold: assert property (p_hold)
    else $error("packet changed while stalled");
  property p_take; wr_valid_in && wr_ready_out |=> !wr_ready_out; endproperty
  a_take: assert property (p_take)
    else $error("ready stayed high after a take");
  property p_mask; pkt_valid_out |-> pkt_out.mask != '0; endproperty
  a_mask: assert property (p_mask)
    else $error("packet without valid bytes");
endmodule

// ===== mswc_link_model.sv
// link-side model: takes line packets, logs them, counts chained bursts
// assumes stall_in changes just after the clock edge
`timescale 1ns/100ps
module mswc_link_model (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic pkt_valid_in,
  input wire mswc_pkg::mswc_pkt_s pkt_in,
  input wire logic stall_in,
  output logic pkt_ready_out
);
  mswc_pkg::mswc_pkt_s got_q[$];
  int bursts = 0;
  logic [mswc_pkg::LINE_ADDR_W-1:0] last_line = '0;
  assign pkt_ready_out = !stall_in;
  always @(posedge clk_sys_in) begin
    if (reset_n_in && pkt_valid_in && pkt_ready_out) begin
      // an ascending neighbour joins the open burst, anything else starts one
      if (got_q.size() == 0 || pkt_in.line_addr != last_line + 1'b1) begin
        bursts = bursts + 1;
      end
      last_line = pkt_in.line_addr;
      got_q.push_back(pkt_in);
    end
  end
endmodule

// ===== tb_top.sv
// self-checking bench of the write combiner with the link model
// assumes package, fifo, top, model and checker compiled first
`timescale 1ns/100ps
module tb_top;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic wr_valid_in = 1'b0;
  mswc_pkg::mswc_wr_s wr_req_in = '0;
  logic flush_in = 1'b0;
  logic uc_read_in = 1'b0;
  logic stall = 1'b0;
  logic wr_ready_out, pkt_valid_out, pkt_ready_in, draining_out;
  mswc_pkg::mswc_pkt_s pkt_out;
  logic [2:0] open_count_out;
  int fails = 0;
  int n_tests = 0;
  typedef struct {logic [25:0] a; logic [25:0] b; int br;} mswc_row_s;
  mswc_row_s rows[4] = '{'{26'h1, 26'h0, 2}, '{26'h0, 26'h1, 1}, '{26'h7, 26'h2, 2},
    '{26'h2, 26'h3, 1}};
  always #5 clk_sys_in = ~clk_sys_in;
  mswc_top dut_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .wr_valid_in(wr_valid_in),
    .wr_req_in(wr_req_in), .wr_ready_out(wr_ready_out), .flush_in(flush_in),
    .uc_read_in(uc_read_in), .pkt_valid_out(pkt_valid_out), .pkt_ready_in(pkt_ready_in),
    .pkt_out(pkt_out), .open_count_out(open_count_out), .draining_out(draining_out));
  mswc_link_model link_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .pkt_valid_in(pkt_valid_out), .pkt_in(pkt_out), .stall_in(stall),
    .pkt_ready_out(pkt_ready_in));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [25:0] a, input logic [2:0] q, input logic [7:0] be,
      input mswc_pkg::mswc_mtype_e t);
    @(posedge clk_sys_in);
    #1 wr_req_in = '{a, q, {8{a[7:0]}}, be, t};
    wr_valid_in = 1'b1;
    // ready is a register: its settled value decides the next edge
    while (wr_ready_out !== 1'b1) begin
      @(posedge clk_sys_in);
      #1;
    end
    @(posedge clk_sys_in);
    #1 wr_valid_in = 1'b0;
  endtask
  task automatic pulse(input bit uc);
    @(posedge clk_sys_in);
    #1 flush_in = !uc;
    uc_read_in = uc;
    @(posedge clk_sys_in);
    #1 flush_in = 1'b0;
    uc_read_in = 1'b0;
  endtask
  task automatic waitpk(input int n);
    for (int i = 0; i < 300 && link_u.got_q.size() < n; i++) @(posedge clk_sys_in);
    chk(link_u.got_q.size(), n);
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // whole run needs under 2000 cycles
  initial begin
    #50000 fails++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk_sys_in);
    #1 reset_n_in = 1'b1;
    chk(open_count_out, 0);
    chk(pkt_valid_out, 0);
    foreach (rows[i]) begin
      link_u.got_q.delete();
      link_u.bursts = 0;
      wr(rows[i].a, 3'h0, 8'hff, mswc_pkg::write_combining_type);
      wr(rows[i].b, 3'h5, 8'h0f, mswc_pkg::streaming_store_type);
      pulse(i[0]);
      waitpk(2);
      chk(link_u.got_q[0].line_addr, rows[i].a);
      chk(link_u.got_q[1].mask, 64'h0000_0f00_0000_0000);
      chk(link_u.bursts, rows[i].br);
    end
    // uncacheable write drains the open line, then leaves alone
    link_u.got_q.delete();
    wr(26'h30, 3'h0, 8'hff, mswc_pkg::write_combining_type);
    wr(26'h31, 3'h2, 8'h03, mswc_pkg::uncacheable_type);
    waitpk(2);
    chk(link_u.got_q[0].line_addr, 26'h30);
    chk(link_u.got_q[1].mask, 64'h0000_0000_0003_0000);
    chk(open_count_out, 0);
    // merge out of order until full, the full line leaves unflushed
    link_u.got_q.delete();
    wr(26'h9, 3'h0, 8'hff, mswc_pkg::write_combining_type);
    wr(26'h8, 3'h0, 8'hff, mswc_pkg::write_combining_type);
    for (int q = 7; q > 0; q--) wr(26'h9, q[2:0], 8'hff, mswc_pkg::write_combining_type);
    waitpk(1);
    chk(link_u.got_q[0].mask, mswc_pkg::MASK_FULL);
    chk(link_u.got_q[0].data[63:0], 64'h0909_0909_0909_0909);
    chk(open_count_out, 1);
    pulse(1'b0);
    waitpk(2);
    chk(link_u.got_q[1].line_addr, 26'h8);
    // a fifth line evicts the oldest, then a stalled flush fills the fifo
    link_u.got_q.delete();
    for (int l = 10; l < 15; l++) wr(l[25:0], 3'h1, 8'h01, mswc_pkg::write_combining_type);
    waitpk(1);
    chk(link_u.got_q[0].line_addr, 26'ha);
    chk(open_count_out, 4);
    #1 stall = 1'b1;
    pulse(1'b0);
    chk(draining_out, 1);
    repeat (10) @(posedge clk_sys_in);
    chk(pkt_valid_out, 1);
    chk(link_u.got_q.size(), 1);
    #1 stall = 1'b0;
    waitpk(5);
    for (int k = 1; k < 5; k++) chk(link_u.got_q[k].line_addr, k + 10);
    chk(open_count_out, 0);
    chk(draining_out, 0);
    // reset in mid-run empties everything
    wr(26'h20, 3'h0, 8'hff, mswc_pkg::write_combining_type);
    @(posedge clk_sys_in);
    #1 reset_n_in = 1'b0;
    @(posedge clk_sys_in);
    #1 reset_n_in = 1'b1;
    chk(open_count_out, 0);
    chk(pkt_valid_out, 0);
    chk(wr_ready_out, 1);
    chk(draining_out, 0);
    give_verdict();
  end
endmodule
bind mswc_top mswc_top_sva #(.NUM_BUFS_P(NUM_BUFS_P)) chk_u (.clk_sys_in(clk_sys_in),
  .reset_n_in(reset_n_in), .wr_valid_in(wr_valid_in), .wr_req_in(wr_req_in),
  .wr_ready_out(wr_ready_out), .flush_in(flush_in), .uc_read_in(uc_read_in),
  .pkt_valid_out(pkt_valid_out), .pkt_ready_in(pkt_ready_in), .pkt_out(pkt_out),
  .open_count_out(open_count_out), .draining_out(draining_out));
